// *** logic/srad_defs.svh ***
// Constants for the serial register access dispatch block.
`ifndef SRAD_DEFS_SVH
`define SRAD_DEFS_SVH
`define SRAD_SEL_COMM 3'h0
`define SRAD_SEL_MODE 3'h1
`define SRAD_SEL_FHI 3'h2
`define SRAD_SEL_FLO 3'h3
`define SRAD_SEL_TEST 3'h4
`define SRAD_SEL_DATA 3'h5
`define SRAD_SEL_ZERO 3'h6
`define SRAD_SEL_FULL 3'h7
`define SRAD_RW_READ 1'h1
`define SRAD_CMD_RW_BIT 3
`define SRAD_CHAN_RESET 3'h4
`define SRAD_FHI_WL_BIT 6
`define SRAD_FHI_UNI_BIT 5
`define SRAD_ZERO_RESET 24'h000000
`define SRAD_FULL_RESET 24'h800000
`define SRAD_RESYNC_ONES 6'h20
`define SRAD_BITS_BYTE 5'h08
`define SRAD_BITS_SHORT 5'h10
`define SRAD_BITS_LONG 5'h18
`define SRAD_ADDR_STATUS 12'h000
`define SRAD_ADDR_MASK 12'h004
`define SRAD_ADDR_VIEW 12'h008
`define SRAD_EV_CMD 0
`define SRAD_EV_WRITE 1
`define SRAD_EV_READ 2
`define SRAD_EV_SYNC 3
`define SRAD_EV_WIDTH 4
`endif

// *** logic/srad_pkg.sv ***
// Types shared by the serial register access dispatch block.
`include "srad_defs.svh"
package srad_pkg;
	typedef enum logic [1:0] {SRAD_IDLE, SRAD_CMD, SRAD_WRITE, SRAD_READ} srad_state_type;
	typedef struct packed {
		srad_state_type state;
		logic sclkS1;
		logic sclkS2;
		logic sclkPrev;
		logic dinS1;
		logic dinS2;
		logic [5:0] onesCnt;
		logic [4:0] bitCnt;
		logic [23:0] shiftIn;
		logic [23:0] shiftOut;
		logic dout;
		logic [2:0] cmdSel;
		logic cmdRw;
		logic [2:0] chan;
		logic [7:0] modeReg;
		logic [7:0] filtHi;
		logic [7:0] filtLo;
		logic [7:0] testReg;
		logic [23:0] dataReg;
		logic [2:0][23:0] zeroCal;
		logic [2:0][23:0] fullCal;
		logic convReadyN;
		logic [`SRAD_EV_WIDTH-1:0] status;
		logic [`SRAD_EV_WIDTH-1:0] mask;
		logic [31:0] prdata;
		logic pslverr;
	} srad_regs_type;
endpackage

// *** logic/srad_serial_regs.sv ***
// Serial command interpreter and register file with an APB side for events.
`timescale 1ns/100ps
`include "srad_defs.svh"
module srad_serial_regs
	import srad_pkg::*;
(
	input wire logic mclk,
	input wire logic reset,
	input wire logic sclk,
	input wire logic din,
	output logic dout,
	output logic doutEn,
	input wire logic [23:0] convData,
	input wire logic convStrobe,
	output logic conversion_ready_n,
	output logic [2:0] channel_select,
	output logic [7:0] modeSetting,
	output logic [7:0] filterHigh,
	output logic [7:0] filterLow,
	output logic [7:0] testSetting,
	output logic [23:0] zeroScale,
	output logic [23:0] fullScale,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq
);

	srad_regs_type st;
	srad_regs_type next_st;
	logic rise;
	logic fall;
	logic [23:0] word;
	logic [`SRAD_EV_WIDTH-1:0] ev;
	logic [`SRAD_EV_WIDTH-1:0] clr;
	logic apbWrite;
	logic apbSetup;
	logic mapped;

	// Channels share calibration pairs; test mode uses the last pair.
	function automatic logic [1:0] calPair(input logic [2:0] ch);
		unique case (ch)
			3'h0, 3'h4: calPair = 2'h0;
			3'h1, 3'h5: calPair = 2'h1;
			default: calPair = 2'h2;
		endcase
	endfunction

	function automatic logic [4:0] regBits(input logic [2:0] sel, input logic wl24);
		if (sel == `SRAD_SEL_DATA) begin
			regBits = wl24 ? `SRAD_BITS_LONG : `SRAD_BITS_SHORT;
		end else if (sel == `SRAD_SEL_ZERO || sel == `SRAD_SEL_FULL) begin
			regBits = `SRAD_BITS_LONG;
		end else begin
			regBits = `SRAD_BITS_BYTE;
		end
	endfunction

	// Only the second synchroniser stage and its delayed copy are looked at.
	assign rise = st.sclkS2 & ~st.sclkPrev;
	assign fall = ~st.sclkS2 & st.sclkPrev;
	assign word = {st.shiftIn[22:0], st.dinS2};
	assign apbSetup = psel & ~penable;
	assign apbWrite = psel & penable & pwrite;
	assign mapped = paddr == `SRAD_ADDR_STATUS || paddr == `SRAD_ADDR_MASK || paddr == `SRAD_ADDR_VIEW;

	always_comb begin
		next_st = st;
		ev = '0;
		clr = '0;
		next_st.sclkS1 = sclk;
		next_st.sclkS2 = st.sclkS1;
		next_st.sclkPrev = st.sclkS2;
		next_st.dinS1 = din;
		next_st.dinS2 = st.dinS1;
		if (convStrobe) begin
			next_st.dataReg = convData;
		end
		if (fall && st.state == SRAD_READ) begin
			next_st.dout = st.shiftOut[23];
			next_st.shiftOut = {st.shiftOut[22:0], 1'h0};
		end
		if (rise) begin
			next_st.shiftIn = word;
			next_st.bitCnt = st.bitCnt - 5'h01;
			if (!st.dinS2) begin
				next_st.onesCnt = '0;
			end else if (st.onesCnt != `SRAD_RESYNC_ONES) begin
				next_st.onesCnt = st.onesCnt + 6'h01;
			end
			unique case (st.state)
				SRAD_IDLE: begin
					// A leading one keeps the interface parked on the gate bit.
					if (!st.dinS2) begin
						next_st.state = SRAD_CMD;
						next_st.bitCnt = `SRAD_BITS_BYTE - 5'h01;
					end
				end
				SRAD_CMD: begin
					if (st.bitCnt == 5'h01) begin
						ev[`SRAD_EV_CMD] = 1'b1;
						next_st.chan = word[2:0];
						next_st.cmdRw = word[`SRAD_CMD_RW_BIT];
						next_st.cmdSel = word[6:4];
						next_st.bitCnt = regBits(word[6:4], st.filtHi[`SRAD_FHI_WL_BIT]);
						if (word[`SRAD_CMD_RW_BIT] == `SRAD_RW_READ) begin
							next_st.state = SRAD_READ;
							unique case (word[6:4])
								`SRAD_SEL_COMM: begin
									// The gate bit position returns the ready flag.
									next_st.shiftOut = {st.convReadyN, word[6:0], 16'h0000};
								end
								`SRAD_SEL_MODE: next_st.shiftOut = {st.modeReg, 16'h0000};
								`SRAD_SEL_FHI: next_st.shiftOut = {st.filtHi, 16'h0000};
								`SRAD_SEL_FLO: next_st.shiftOut = {st.filtLo, 16'h0000};
								`SRAD_SEL_TEST: next_st.shiftOut = {st.testReg, 16'h0000};
								`SRAD_SEL_DATA: begin
									if (st.filtHi[`SRAD_FHI_WL_BIT]) begin
										next_st.shiftOut = st.dataReg;
									end else begin
										next_st.shiftOut = {st.dataReg[23:8], 8'h00};
									end
								end
								`SRAD_SEL_ZERO: next_st.shiftOut = st.zeroCal[calPair(word[2:0])];
								`SRAD_SEL_FULL: next_st.shiftOut = st.fullCal[calPair(word[2:0])];
							endcase
						end else if (word[6:4] == `SRAD_SEL_COMM) begin
							// Writing the command register with itself as target ends the access.
							next_st.state = SRAD_IDLE;
						end else begin
							next_st.state = SRAD_WRITE;
						end
					end
				end
				SRAD_WRITE: begin
					if (st.bitCnt == 5'h01) begin
						ev[`SRAD_EV_WRITE] = 1'b1;
						next_st.state = SRAD_IDLE;
						unique case (st.cmdSel)
							`SRAD_SEL_MODE: next_st.modeReg = word[7:0];
							`SRAD_SEL_FHI: next_st.filtHi = word[7:0];
							`SRAD_SEL_FLO: next_st.filtLo = word[7:0];
							`SRAD_SEL_TEST: next_st.testReg = word[7:0];
							`SRAD_SEL_ZERO: next_st.zeroCal[calPair(st.chan)] = word;
							`SRAD_SEL_FULL: next_st.fullCal[calPair(st.chan)] = word;
							default: begin
								// The data register only carries conversion results.
							end
						endcase
					end
				end
				SRAD_READ: begin
					if (st.bitCnt == 5'h01) begin
						ev[`SRAD_EV_READ] = 1'b1;
						next_st.state = SRAD_IDLE;
						if (st.cmdSel == `SRAD_SEL_DATA) begin
							next_st.convReadyN = 1'b1;
						end
					end
				end
			endcase
			// Lost framing is recovered no matter where the sequence stood.
			if (st.dinS2 && st.onesCnt == `SRAD_RESYNC_ONES - 6'h01) begin
				next_st.state = SRAD_IDLE;
				ev[`SRAD_EV_SYNC] = st.state != SRAD_IDLE;
			end
		end
		// Fresh data wins over a read that finishes in the same cycle.
		if (convStrobe) begin
			next_st.convReadyN = 1'b0;
		end
		if (apbWrite && paddr == `SRAD_ADDR_STATUS) begin
			clr = pwdata[`SRAD_EV_WIDTH-1:0];
		end
		if (apbWrite && paddr == `SRAD_ADDR_MASK) begin
			next_st.mask = pwdata[`SRAD_EV_WIDTH-1:0];
		end
		next_st.status = (st.status & ~clr) | ev;
		if (apbSetup) begin
			next_st.pslverr = ~mapped;
			unique case (paddr)
				`SRAD_ADDR_STATUS: next_st.prdata = {28'h0000000, st.status};
				`SRAD_ADDR_MASK: next_st.prdata = {28'h0000000, st.mask};
				`SRAD_ADDR_VIEW: begin
					next_st.prdata = {22'h0, st.state, st.convReadyN, st.cmdSel, st.cmdRw, st.chan};
				end
				default: next_st.prdata = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			st <= '0;
			st.state <= SRAD_IDLE;
			st.chan <= `SRAD_CHAN_RESET;
			st.convReadyN <= 1'b1;
			st.sclkS1 <= 1'b1;
			st.sclkS2 <= 1'b1;
			st.sclkPrev <= 1'b1;
			st.zeroCal <= {3{`SRAD_ZERO_RESET}};
			st.fullCal <= {3{`SRAD_FULL_RESET}};
		end else begin
			st <= next_st;
		end
	end

	assign dout = st.dout;
	assign doutEn = st.state == SRAD_READ;
	assign conversion_ready_n = st.convReadyN;
	assign channel_select = st.chan;
	assign modeSetting = st.modeReg;
	assign filterHigh = st.filtHi;
	assign filterLow = st.filtLo;
	assign testSetting = st.testReg;
	assign zeroScale = st.zeroCal[calPair(st.chan)];
	assign fullScale = st.fullCal[calPair(st.chan)];
	assign prdata = st.prdata;
	assign pslverr = st.pslverr & psel & penable;
	assign pready = psel & penable;
	assign irq = |(st.status & st.mask);

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (reset);

	sequence lastBitIn(srad_state_type s);
		rise && st.state == s && st.bitCnt == 5'h01;
	endsequence

	// A finished command byte whose direction bit asks for a read.
	sequence cmdReadEnd;
		lastBitIn(SRAD_CMD) and word[`SRAD_CMD_RW_BIT] == `SRAD_RW_READ;
	endsequence

	chk_reset_idle: assert property (@(posedge mclk) disable iff (1'b0) reset |=> st.state == SRAD_IDLE)
		else $error("interface not idle after reset");
	chk_gate_hold: assert property (rise && st.state == SRAD_IDLE && st.dinS2 |=> st.state == SRAD_IDLE)
		else $error("command started on a leading one");
	chk_resync_ones: assert property (rise && st.dinS2 && st.onesCnt == 6'h1f |=> st.state == SRAD_IDLE)
		else $error("no return to command wait after ones");
	chk_cmd_dir: assert property (st.state == SRAD_CMD ##1 st.state == SRAD_WRITE |-> !st.cmdRw)
		else $error("write access entered on a read command");
	chk_mode_load: assert property (lastBitIn(SRAD_WRITE) and st.cmdSel == `SRAD_SEL_MODE
		|=> st.modeReg == $past(word[7:0]))
		else $error("mode register not loaded");
	chk_read_drive: assert property (cmdReadEnd |=> st.state == SRAD_READ && doutEn)
		else $error("read data not driven");
	chk_ready_clear: assert property (lastBitIn(SRAD_READ) and st.cmdSel == `SRAD_SEL_DATA and !convStrobe
		|=> conversion_ready_n)
		else $error("ready flag not cleared by data read");
	chk_access_end: assert property (lastBitIn(SRAD_WRITE) or lastBitIn(SRAD_READ) |=> st.state == SRAD_IDLE)
		else $error("access did not return to command wait");
	chk_cal_follow: assert property (lastBitIn(SRAD_WRITE) and st.cmdSel == `SRAD_SEL_ZERO
		|=> zeroScale == $past(word))
		else $error("zero-scale view not tied to channel");

	// Loads of the remaining byte registers and of the full-scale pair, and a data register that serial writes leave alone.
	chk_filthi_load: assert property (lastBitIn(SRAD_WRITE) and st.cmdSel == `SRAD_SEL_FHI
		|=> filterHigh == $past(word[7:0]))
		else $error("filter high register not loaded");
	chk_filtlo_load: assert property (lastBitIn(SRAD_WRITE) and st.cmdSel == `SRAD_SEL_FLO
		|=> filterLow == $past(word[7:0]))
		else $error("filter low register not loaded");
	chk_test_load: assert property (lastBitIn(SRAD_WRITE) and st.cmdSel == `SRAD_SEL_TEST
		|=> testSetting == $past(word[7:0]))
		else $error("test register not loaded");
	chk_full_view: assert property (lastBitIn(SRAD_WRITE) and st.cmdSel == `SRAD_SEL_FULL
		|=> fullScale == $past(word))
		else $error("full-scale view not tied to channel");
	chk_data_hold: assert property (lastBitIn(SRAD_WRITE) and st.cmdSel == `SRAD_SEL_DATA and !convStrobe
		|=> st.dataReg == $past(st.dataReg))
		else $error("data register changed by a serial write");

	// Command byte fields and the length of the access that follows.
	chk_cmd_latch: assert property (lastBitIn(SRAD_CMD)
		|=> st.cmdSel == $past(word[6:4]) && channel_select == $past(word[2:0]))
		else $error("command fields not latched");
	chk_data_len: assert property (cmdReadEnd and word[6:4] == `SRAD_SEL_DATA
		|=> st.bitCnt == (filterHigh[`SRAD_FHI_WL_BIT] ? `SRAD_BITS_LONG : `SRAD_BITS_SHORT))
		else $error("data read length wrong");
	chk_cal_len: assert property (lastBitIn(SRAD_CMD) and word[6:5] == 2'h3
		|=> st.bitCnt == `SRAD_BITS_LONG)
		else $error("calibration access length wrong");
	chk_byte_len: assert property (lastBitIn(SRAD_CMD) and word[6:4] <= `SRAD_SEL_TEST
		|=> st.bitCnt == `SRAD_BITS_BYTE)
		else $error("byte register access length wrong");
	chk_gate_bit: assert property (cmdReadEnd and word[6:4] == `SRAD_SEL_COMM
		|=> st.shiftOut[23] == $past(conversion_ready_n))
		else $error("command read does not lead with the ready flag");

	// Conversion flag, the event registers and the refusal of unmapped addresses on the bus side.
	chk_ready_set: assert property (convStrobe |=> !conversion_ready_n)
		else $error("ready flag not set by a conversion");
	chk_cmd_event: assert property (lastBitIn(SRAD_CMD) |=> st.status[`SRAD_EV_CMD])
		else $error("command event not recorded");
	chk_mask_write: assert property (apbWrite && paddr == `SRAD_ADDR_MASK
		|=> st.mask == $past(pwdata[`SRAD_EV_WIDTH-1:0]))
		else $error("mask register not written");
	chk_apb_error: assert property (psel && penable && !mapped |-> pslverr && prdata == 32'h00000000)
		else $error("unmapped access not refused");

endmodule

// *** tb/srad_host.sv ***
// Serial host model that clocks command and register bits over the link.
`timescale 1ns/100ps
module srad_host (
	input wire logic mclk,
	output logic sclk,
	output logic din,
	input wire logic dout,
	output logic rdStrobe,
	output logic [23:0] rdWord
);
	initial begin
		sclk = 1'b1;
		din = 1'b1;
		rdStrobe = 1'b0;
		rdWord = 24'h000000;
	end
	// Each bit is 10 cycles low then 10 high, 160 ns; the clock rests high between frames.
	task automatic shift(input logic [31:0] val, input int n, input logic rd);
		logic [23:0] got;
		got = 24'h000000;
		for (int i = n - 1; i >= 0; i--) begin
			sclk <= 1'b0;
			din <= val[i];
			repeat (10) @(posedge mclk);
			got = {got[22:0], dout};
			sclk <= 1'b1;
			repeat (10) @(posedge mclk);
		end
		// A released data line must not keep looking like the last bit.
		din <= ~val[0];
		rdStrobe <= rd;
		rdWord <= got;
		@(posedge mclk);
		rdStrobe <= 1'b0;
	endtask
endmodule

// *** tb/tb.sv ***
// Self-checking bench: serial traffic, conversions and the event registers.
`timescale 1ns/100ps
`include "srad_defs.svh"
module tb;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic convStrobe = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic apbStrobe = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, apbWord, seed = 32'h3b;
	logic [23:0] convData = 24'h0, zeroScale, fullScale, rdWord, conv, cal;
	logic [7:0] modeSetting, filterHigh, filterLow, testSetting;
	logic [7:0] val [1:4];
	logic [2:0] channel_select;
	logic sclk, din, dout, doutEn, conversion_ready_n, pready, pslverr, irq, rdStrobe;
	logic [31:0] expQ [$];
	int failCount = 0;
	int compares = 0;
	always #4 mclk = ~mclk;
	srad_serial_regs dut (.mclk, .reset, .sclk, .din, .dout, .doutEn, .convData, .convStrobe, .conversion_ready_n,
		.channel_select, .modeSetting, .filterHigh, .filterLow, .testSetting, .zeroScale, .fullScale, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq);
	srad_host host (.mclk, .sclk, .din, .dout, .rdStrobe, .rdWord);
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic [7:0] cmd(input logic [2:0] sel, input logic rd, input logic [2:0] ch);
		return {1'b0, sel, rd, ch};
	endfunction
	task automatic completeRun();
		$display("compares %0d, mismatches %0d", compares, failCount);
		if (failCount == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			failCount++;
			$display("unexpected at %0t: expected %h, got %h", $time, exp, got);
		end
	endtask
	always @(posedge mclk) begin
		if (rdStrobe === 1'b1 || apbStrobe === 1'b1)
			check(expQ.size() > 0 ? expQ.pop_front() : 'x, rdStrobe === 1'b1 ? {8'h0, rdWord} : apbWord);
	end
	// Every access opens with a command byte; a read then clocks out n bits.
	task automatic ser(input logic [7:0] c, input logic [23:0] data, input int n);
		host.shift({24'h0, c}, 8, 1'b0);
		if (c[`SRAD_CMD_RW_BIT]) begin
			expQ.push_back({8'h0, data});
			check(32'h1, {31'h0, doutEn});
			host.shift(32'h0, n, 1'b1);
			check(32'h0, {31'h0, doutEn});
		end else
			host.shift({8'h0, data}, n, 1'b0);
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic err);
		int k;
		k = 0;
		if (!wr)
			expQ.push_back(d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k >= 50) begin
			failCount++;
			completeRun();
		end
		check({31'h0, err}, {31'h0, pslverr});
		apbWord <= prdata;
		apbStrobe <= !wr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
		apbStrobe <= 1'b0;
		@(posedge mclk);
	endtask
	initial begin
		repeat (10) @(posedge mclk);
		reset <= 1'b0;
		repeat (5) @(posedge mclk);
		ser(cmd(`SRAD_SEL_COMM, 1'b1, 3'h4), 24'h8c, 8);
		for (int s = 1; s <= 4; s++) begin
			val[s] = 8'(rnd());
			ser(cmd(3'(s), 1'b0, 3'h4), {16'h0, val[s]}, 8);
			ser(cmd(3'(s), 1'b1, 3'h4), {16'h0, val[s]}, 8);
		end
		check({val[1], val[2], val[3], val[4]}, {modeSetting, filterHigh, filterLow, testSetting});
		val[1] = 8'(rnd());
		host.shift({22'h0, 2'b11, cmd(`SRAD_SEL_MODE, 1'b0, 3'h4)}, 10, 1'b0);
		host.shift({24'h0, val[1]}, 8, 1'b0);
		ser(cmd(`SRAD_SEL_MODE, 1'b1, 3'h4), {16'h0, val[1]}, 8);
		conv = 24'(rnd());
		@(posedge mclk);
		convData <= conv;
		convStrobe <= 1'b1;
		@(posedge mclk);
		convStrobe <= 1'b0;
		@(posedge mclk);
		check(32'h0, {31'h0, conversion_ready_n});
		ser(cmd(`SRAD_SEL_DATA, 1'b1, 3'h4), val[2][6] ? conv : {8'h0, conv[23:8]}, val[2][6] ? 24 : 16);
		check(32'h1, {31'h0, conversion_ready_n});
		cal = 24'(rnd());
		ser(cmd(`SRAD_SEL_ZERO, 1'b0, 3'h5), cal, 24);
		ser(cmd(`SRAD_SEL_ZERO, 1'b1, 3'h5), cal, 24);
		check({8'h0, cal}, {8'h0, zeroScale});
		ser(cmd(`SRAD_SEL_FULL, 1'b1, 3'h5), `SRAD_FULL_RESET, 24);
		check({8'h0, `SRAD_FULL_RESET}, {8'h0, fullScale});
		ser(cmd(`SRAD_SEL_ZERO, 1'b1, 3'h0), `SRAD_ZERO_RESET, 24);
		check(32'h0, {29'h0, channel_select});
		host.shift(32'h0, 1, 1'b0);
		host.shift(32'hffffffff, 32, 1'b0);
		ser(cmd(`SRAD_SEL_FLO, 1'b1, 3'h4), {16'h0, val[3]}, 8);
		apb(1'b0, `SRAD_ADDR_STATUS, 32'h7, 1'b0);
		check(32'h0, {31'h0, irq});
		apb(1'b1, `SRAD_ADDR_MASK, 32'h2, 1'b0);
		check(32'h1, {31'h0, irq});
		apb(1'b1, `SRAD_ADDR_STATUS, 32'h2, 1'b0);
		check(32'h0, {31'h0, irq});
		apb(1'b0, `SRAD_ADDR_STATUS, 32'h5, 1'b0);
		apb(1'b0, `SRAD_ADDR_MASK, 32'h2, 1'b0);
		apb(1'b0, 12'h00c, 32'h0, 1'b1);
		repeat (3) @(posedge mclk);
		completeRun();
	end
endmodule
